// File: src/two_supply_gate_sequencer.sv
// two-supply gate sequencer: qualification, delay, lockout and gate drive
//
// Function
// - gate rises only after enable held full delay
// - enable low drops gate at once
// - enable judged like primary monitor input
// - capacitor variant delay scales with capacitance
// - primary monitor low drops gate at once
// - both supplies under lockout hold gate low
// - either supply above lockout permits drive
// - fixed variant delay 300 ms, enable first
// - timer starts only when both inputs qualify
// - enabled gate driven above supply by pump
// - fixed delay between 240 and 350 ms
`timescale 1ns/1ps
`default_nettype none
`include "gate_seq_consts.svh"

module two_supply_gate_sequencer #(
  parameter bit FIXED_VARIANT = 1'b1,              // 1: enable input, fixed delay
  parameter int DELAY_CYCLES  = `SEQ_DELAY_CYCLES, // fixed delay in clocks
  parameter int PUMP_DIV      = `PUMP_DIV_CYCLES,  // clocks per pump half period
  parameter int CAP_W         = 16,                // capacitance code width, pF
  parameter int CNT_W         = 32                 // delay counter width
) (
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  input  wire logic             supplyOneOk,       // supply_one above lockout level
  input  wire logic             supplyTwoOk,       // supply_two above lockout level
  input  wire logic             primaryMonitorIn,  // primary monitor above threshold
  input  wire logic             enableQualIn,      // enable comparator above threshold
  input  wire logic [CAP_W-1:0] delayCapacitorPin, // capacitance in pF
  output logic                  gateDrive,         // switch drive on
  output logic                  chargePumpClk,     // pump clock, runs only while on
  output logic                  lockoutActive,     // both supplies under lockout
  output logic                  timerRunning       // delay being counted
);
  import gate_seq_pkg::*;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------

  // capacitance in pF to clock cycles, rounded down, at least one
  function automatic logic [CNT_W-1:0] capCycles(input logic [CAP_W-1:0] pf);
    logic [CAP_W+15:0] ns;
    logic [CAP_W+15:0] cyc;
    ns  = (CAP_W+16)'(pf) * (CAP_W+16)'(`CAP_DELAY_NS_PER_PF);
    cyc = ns / (CAP_W+16)'(`CLK_PERIOD_NS);
    if (cyc == '0) begin
      cyc = (CAP_W+16)'(1);
    end
    return CNT_W'(cyc);
  endfunction : capCycles

  // both comparators judged at the same threshold level
  function automatic logic qualifies(input logic mon, input logic en);
    return mon && (en || !FIXED_VARIANT);
  endfunction : qualifies

  // ---------------------------------------------------------------
  // qualification
  // ---------------------------------------------------------------

  logic             supplyOn;     // at least one supply past lockout
  logic             qualified;    // monitor good, and enable too in the fixed variant
  logic [CNT_W-1:0] delayTarget;  // delay length in clocks
  logic [CNT_W-1:0] timerCount;   // elapsed qualified clocks
  logic             timerDone;    // full delay counted
  logic             timerRun;     // count enable for the timer

  // either supply may be the one that powers the logic
  assign supplyOn  = supplyOneOk || supplyTwoOk;
  // enable uses the same comparison as the monitor
  assign qualified = qualifies(primaryMonitorIn, enableQualIn);

  // fixed delay or one set by the external capacitor
  assign delayTarget = FIXED_VARIANT ? CNT_W'(DELAY_CYCLES)
                                     : capCycles(delayCapacitorPin);

  // ---------------------------------------------------------------
  // sequencing state
  // ---------------------------------------------------------------

  seq_state_t state;       // current state
  seq_state_t next_state;  // next state

  // timer runs only while both inputs stay good; any drop clears it
  assign timerRun = supplyOn && qualified
                 && (state == ST_IDLE || state == ST_COUNT);

  seq_delay_timer #(
    .W (CNT_W)
  ) u_timer (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .run     (timerRun),
    .target  (delayTarget),
    .count   (timerCount),
    .done    (timerDone)
  );

  // next state; lockout and disqualification win over everything
  always_comb begin
    next_state = state;
    unique case (state)
      // held off until a supply comes up
      ST_LOCKOUT: begin
        if (supplyOn) begin
          next_state = ST_IDLE;
        end
      end
      // waiting for both inputs
      ST_IDLE: begin
        if (!supplyOn) begin
          next_state = ST_LOCKOUT;
        end else if (qualified) begin
          next_state = ST_COUNT;
        end
      end
      // delay in progress; a drop restarts from scratch
      ST_COUNT: begin
        if (!supplyOn) begin
          next_state = ST_LOCKOUT;
        end else if (!qualified) begin
          next_state = ST_IDLE;
        end else if (timerDone) begin
          next_state = ST_ON;
        end
      end
      // switch on; turn-off needs no delay
      ST_ON: begin
        if (!supplyOn) begin
          next_state = ST_LOCKOUT;
        end else if (!qualified) begin
          next_state = ST_IDLE;
        end
      end
      // any illegal code falls back to the safe state
      default: begin
        next_state = ST_LOCKOUT;
      end
    endcase
  end

  // register only
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state <= ST_LOCKOUT;
    end else begin
      state <= next_state;
    end
  end

  // ---------------------------------------------------------------
  // charge pump divider
  // ---------------------------------------------------------------

  logic [15:0] pumpDiv;       // divider count
  logic [15:0] next_pumpDiv;  // divider next value
  logic        pumpTick;      // one-cycle enable at pump rate

  // free-running divider; the pump only uses it while switched on
  always_comb begin
    pumpTick = (pumpDiv == 16'(PUMP_DIV - 1));
    if (pumpTick) begin
      next_pumpDiv = 16'h0000;
    end else begin
      next_pumpDiv = pumpDiv + 16'h0001;
    end
  end

  // register only
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pumpDiv <= 16'h0000;
    end else begin
      pumpDiv <= next_pumpDiv;
    end
  end

  // ---------------------------------------------------------------
  // outputs, all registered
  // ---------------------------------------------------------------

  logic next_gateDrive;      // gate next value
  logic next_chargePumpClk;  // pump clock next value
  logic next_lockoutActive;  // lockout flag next value
  logic next_timerRunning;   // timer flag next value

  // gate follows the next state so turn-off costs one edge only
  always_comb begin
    next_gateDrive     = (next_state == ST_ON);
    next_lockoutActive = (next_state == ST_LOCKOUT);
    next_timerRunning  = timerRun;
    // pump toggles only while on, lifting the gate above the supply
    if (!next_gateDrive) begin
      next_chargePumpClk = 1'b0;
    end else if (pumpTick) begin
      next_chargePumpClk = !chargePumpClk;
    end else begin
      next_chargePumpClk = chargePumpClk;
    end
  end

  // register only
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      gateDrive     <= `GATE_RESET;
      chargePumpClk <= `PUMP_RESET;
      lockoutActive <= `LOCK_RESET;
      timerRunning  <= `TIMER_FLAG_RESET;
    end else begin
      gateDrive     <= next_gateDrive;
      chargePumpClk <= next_chargePumpClk;
      lockoutActive <= next_lockoutActive;
      timerRunning  <= next_timerRunning;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  // gate rises only once the timer has reached the full delay
  property p_rise_after_delay;
    $rose(gateDrive) |-> $past(timerCount) == $past(delayTarget);
  endproperty
  a_rise_after_delay: assert property (p_rise_after_delay)
    else $error("gate rose before full delay");

  // enable low drops the gate on the next edge
  property p_enable_drop;
    (FIXED_VARIANT && !enableQualIn) |=> !gateDrive;
  endproperty
  a_enable_drop: assert property (p_enable_drop)
    else $error("gate stayed on with enable low");

  // a mismatch of the two comparators never leaves the gate on
  property p_same_threshold;
    (FIXED_VARIANT && (primaryMonitorIn != enableQualIn)) |=> !gateDrive && !timerRunning;
  endproperty
  a_same_threshold: assert property (p_same_threshold)
    else $error("one comparator alone qualified");

  // capacitor variant rises after pF times the per-pF delay, worked out apart from capCycles
  property p_cap_delay;
    (!FIXED_VARIANT && $rose(gateDrive) && ($past(delayCapacitorPin) != '0))
      |-> $past(timerCount) == CNT_W'((int'($past(delayCapacitorPin))
                                        * `CAP_DELAY_NS_PER_PF) / `CLK_PERIOD_NS);
  endproperty
  a_cap_delay: assert property (p_cap_delay)
    else $error("capacitor delay target wrong");

  // primary monitor low drops the gate on the next edge
  property p_monitor_drop;
    !primaryMonitorIn |=> !gateDrive ##0 !chargePumpClk;
  endproperty
  a_monitor_drop: assert property (p_monitor_drop)
    else $error("gate stayed on with monitor low");

  // both supplies under lockout keep everything off
  property p_lockout;
    !(supplyOneOk || supplyTwoOk) |=> lockoutActive && !gateDrive && timerCount == '0;
  endproperty
  a_lockout: assert property (p_lockout)
    else $error("gate not held off in lockout");

  // one good supply is enough to keep the gate on
  property p_one_supply;
    (gateDrive && (supplyOneOk ^ supplyTwoOk) && qualified) |=> gateDrive;
  endproperty
  a_one_supply: assert property (p_one_supply)
    else $error("gate dropped with one supply good");

  // fixed variant rises after exactly DELAY_CYCLES counted clocks
  property p_fixed_delay;
    (FIXED_VARIANT && $rose(gateDrive)) |-> $past(timerCount) == CNT_W'(DELAY_CYCLES);
  endproperty
  a_fixed_delay: assert property (p_fixed_delay)
    else $error("fixed delay length wrong");

  // timer advances only when both inputs were good
  property p_timer_start;
    (timerCount != '0) |-> $past(qualified && supplyOn);
  endproperty
  a_timer_start: assert property (p_timer_start)
    else $error("timer counted without qualification");

  // pump clock only runs with the gate on
  property p_pump_gated;
    !gateDrive |-> !chargePumpClk;
  endproperty
  a_pump_gated: assert property (p_pump_gated)
    else $error("pump running with gate off");

  // disqualification clears the timer at once
  property p_timer_clear;
    !qualified |=> timerCount == '0;
  endproperty
  a_timer_clear: assert property (p_timer_clear)
    else $error("timer kept count after drop");

  // main scenarios
  c_gate_on:   cover property ($rose(gateDrive));
  c_abort:     cover property (timerRunning ##1 !qualified);
  c_lockout_on: cover property (gateDrive ##1 !supplyOn);

endmodule : two_supply_gate_sequencer

`default_nettype wire

// File: src/gate_seq_consts.svh
// timing and reset constants for the two-supply gate sequencer
`ifndef GATE_SEQ_CONSTS_SVH
`define GATE_SEQ_CONSTS_SVH

`define CLK_PERIOD_NS       10
`define SEQ_DELAY_MS        300
`define SEQ_DELAY_MIN_MS    240
`define SEQ_DELAY_MAX_MS    350
`define SEQ_DELAY_CYCLES    ((`SEQ_DELAY_MS * 1000000) / `CLK_PERIOD_NS)
`define SEQ_DELAY_MIN_CYC   ((`SEQ_DELAY_MIN_MS * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SEQ_DELAY_MAX_CYC   ((`SEQ_DELAY_MAX_MS * 1000000) / `CLK_PERIOD_NS)
`define CAP_DELAY_NS_PER_PF 2652
`define PUMP_HALF_NS        500
`define PUMP_DIV_CYCLES     (`PUMP_HALF_NS / `CLK_PERIOD_NS)
`define GATE_RESET          1'b0
`define PUMP_RESET          1'b0
`define LOCK_RESET          1'b1
`define TIMER_FLAG_RESET    1'b0

`endif

// File: src/gate_seq_pkg.sv
// types shared by the gate sequencer files
package gate_seq_pkg;

  // one-hot sequencing states
  typedef enum logic [3:0] {
    ST_LOCKOUT = 4'b0001,
    ST_IDLE    = 4'b0010,
    ST_COUNT   = 4'b0100,
    ST_ON      = 4'b1000
  } seq_state_t;

endpackage : gate_seq_pkg

// File: src/seq_delay_timer.sv
// saturating delay counter, cleared whenever its run level drops
`timescale 1ns/1ps
`default_nettype none

module seq_delay_timer #(
  parameter int W = 32
) (
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  input  wire logic         run,
  input  wire logic [W-1:0] target,
  output logic      [W-1:0] count,
  output logic              done
);

  logic [W-1:0] next_count;  // counter next value

  // count up while running, hold at target, clear at once when stopped
  always_comb begin
    if (!run) begin
      next_count = '0;
    end else if (count >= target) begin
      next_count = count;
    end else begin
      next_count = count + W'(1);
    end
  end

  // register only
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  // done only after the full target has been counted
  assign done = (count >= target);

endmodule : seq_delay_timer

`default_nettype wire

// File: bench/fet_monitor_model.sv
// far-side model: supply lockout comparators, monitor comparators and the pass switch
`timescale 1ns/1ps
`default_nettype none

module fet_monitor_model #(
  parameter int UNDERVOLTAGE_LOCKOUT_MV   = 2525, // lockout level in mV
  parameter int THRESH_MV = 618   // monitor threshold in mV
) (
  input  wire logic        clk_sys,
  input  wire logic [15:0] vccOneMv,
  input  wire logic [15:0] vccTwoMv,
  input  wire logic [15:0] monMv,
  input  wire logic [15:0] enMv,
  input  wire logic        gateDrive,
  input  wire logic        chargePumpClk,
  output logic             supplyOneOk,
  output logic             supplyTwoOk,
  output logic             primaryMonitorIn,
  output logic             enableQualIn,
  output logic             fetOn
);
  int   pumpEdges; // pump transitions seen since the drive came on
  logic pumpLast;  // pump level one clock ago
  // lockout comparators, one per supply
  assign supplyOneOk = vccOneMv > UNDERVOLTAGE_LOCKOUT_MV;
  assign supplyTwoOk = vccTwoMv > UNDERVOLTAGE_LOCKOUT_MV;
  // both monitor inputs share one threshold
  assign primaryMonitorIn = monMv > THRESH_MV;
  assign enableQualIn     = enMv > THRESH_MV;
  // the switch only enhances once the pump has pushed the gate a while
  always_ff @(posedge clk_sys) begin
    if (!gateDrive) begin
      pumpEdges <= 0;
    end else if (chargePumpClk != pumpLast) begin
      pumpEdges <= pumpEdges + 1;
    end
    pumpLast <= chargePumpClk;
  end
  assign fetOn = gateDrive && (pumpEdges >= 2);
endmodule : fet_monitor_model
`default_nettype wire

// File: bench/test_two_supply_gate_sequencer.sv
// self-checking bench for the two-supply gate sequencer
`timescale 1ns/1ps
`default_nettype none

module test_two_supply_gate_sequencer;
  localparam int DLY   = 8;                 // shortened fixed delay
  localparam int CAP_N = (1 * 2652) / 10;   // clocks for a 1 pF capacitor
  localparam logic [15:0] HI = 16'h0CE4;    // 3300 mV supply
  localparam logic [15:0] ON = 16'h02BC;    // 700 mV, above threshold
  localparam logic [15:0] UN = 16'h0258;    // 600 mV, just below threshold
  typedef struct {logic [15:0] v1, v2, mon, en; logic gate, lock;} row_t;
  logic        clk_sys, resetn, gateDrive, chargePumpClk, lockoutActive, timerRunning;
  logic        supplyOneOk, supplyTwoOk, primaryMonitorIn, enableQualIn, fetOn, capGate, p;
  logic [15:0] vccOneMv, vccTwoMv, monMv, enMv, capPf;
  int          errCount, checkCount;
  row_t        rows [7];

  // dut with the fixed delay and enable input
  two_supply_gate_sequencer #(.FIXED_VARIANT(1'b1), .DELAY_CYCLES(DLY), .PUMP_DIV(2))
    two_supply_gate_sequencer_i (.clk_sys(clk_sys), .resetn(resetn),
    .supplyOneOk(supplyOneOk), .supplyTwoOk(supplyTwoOk),
    .primaryMonitorIn(primaryMonitorIn), .enableQualIn(enableQualIn),
    .delayCapacitorPin(capPf), .gateDrive(gateDrive), .chargePumpClk(chargePumpClk),
    .lockoutActive(lockoutActive), .timerRunning(timerRunning));
  // capacitor variant watching the same inputs, 1 pF held static
  two_supply_gate_sequencer #(.FIXED_VARIANT(1'b0), .PUMP_DIV(2))
    cap_two_supply_gate_sequencer_i (.clk_sys(clk_sys), .resetn(resetn),
    .supplyOneOk(supplyOneOk), .supplyTwoOk(supplyTwoOk),
    .primaryMonitorIn(primaryMonitorIn), .enableQualIn(enableQualIn),
    .delayCapacitorPin(capPf), .gateDrive(capGate), .chargePumpClk(),
    .lockoutActive(), .timerRunning());
  fet_monitor_model fet_monitor_model_i (.clk_sys(clk_sys), .vccOneMv(vccOneMv),
    .vccTwoMv(vccTwoMv), .monMv(monMv), .enMv(enMv), .gateDrive(gateDrive),
    .chargePumpClk(chargePumpClk), .supplyOneOk(supplyOneOk), .supplyTwoOk(supplyTwoOk),
    .primaryMonitorIn(primaryMonitorIn), .enableQualIn(enableQualIn), .fetOn(fetOn));

  // free-running 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // one compare for every single-bit result
  task chk(input logic act, input logic exp, input string msg);
    checkCount++;
    if (act !== exp) begin
      errCount++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : chk

  // wait edges, then settle past the edge
  task edges(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : edges

  // new levels land on a rising edge
  task setIn(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c,
             input logic [15:0] d);
    @(posedge clk_sys);
    vccOneMv <= a;
    vccTwoMv <= b;
    monMv    <= c;
    enMv     <= d;
  endtask : setIn

  // verdict in one place
  task stopTest;
    $display("checks %0d errors %0d", checkCount, errCount);
    if (errCount == 0 && checkCount > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stopTest

  // watchdog, well above the ~460 clocks the sequence needs
  initial begin
    repeat (5000) @(posedge clk_sys);
    errCount++;
    stopTest;
  end

  initial begin
    errCount = 0;
    checkCount = 0;
    resetn = 1'b0;
    {vccOneMv, vccTwoMv, monMv, enMv} = '0;
    capPf = 16'h0001;  // 1 pF, held static through the run
    rows = '{'{16'h0, 16'h0, ON, ON, 1'b0, 1'b1},  // both down, locked out
             '{HI, 16'h0, ON, ON, 1'b1, 1'b0},     // supply one alone drives
             '{HI, 16'h0, ON, UN, 1'b0, 1'b0},     // enable just under threshold
             '{16'h0, HI, ON, ON, 1'b1, 1'b0},     // supply two alone drives
             '{16'h0, HI, 16'h0, ON, 1'b0, 1'b0},  // monitor low
             '{HI, HI, ON, ON, 1'b1, 1'b0},        // both supplies up
             '{16'h0, 16'h0, ON, ON, 1'b0, 1'b1}}; // lockout again
    edges(5);
    chk(gateDrive, 1'b0, "gate during reset");
    chk(lockoutActive, 1'b1, "lockout during reset");
    chk(timerRunning, 1'b0, "timer during reset");
    edges(4);
    // release on a rising edge, tenth edge of reset
    @(posedge clk_sys);
    resetn <= 1'b1;
    // table: levels in, gate and lockout out
    foreach (rows[i]) begin
      setIn(rows[i].v1, rows[i].v2, rows[i].mon, rows[i].en);
      edges(DLY + 8);
      chk(gateDrive, rows[i].gate, "row gate");
      chk(lockoutActive, rows[i].lock, "row lock");
    end
    // monitor low with enable high: no counting yet
    setIn(HI, 16'h0, 16'h0, ON);
    edges(DLY + 3);
    chk(timerRunning, 1'b0, "timer ran on enable alone");
    // exact delay from joint qualification
    setIn(HI, 16'h0, ON, ON);
    edges(1);
    chk(timerRunning, 1'b1, "timer idle");
    edges(DLY - 1);
    chk(gateDrive, 1'b0, "gate early");
    edges(1);
    chk(gateDrive, 1'b1, "gate late");
    p = chargePumpClk;
    edges(2);
    chk(chargePumpClk, !p, "pump stalled");
    // capacitor variant counted from the same edge, rises one edge after its count
    edges(CAP_N - DLY - 3);
    chk(capGate, 1'b0, "cap gate early");
    edges(1);
    chk(capGate, 1'b1, "cap gate late");
    chk(fetOn, 1'b1, "switch not enhanced");
    // enable low drops at the next edge
    setIn(HI, 16'h0, ON, 16'h0);
    edges(1);
    chk(gateDrive, 1'b0, "gate held after enable low");
    chk(chargePumpClk, 1'b0, "pump held");
    // one-cycle dropout mid-count restarts the full delay
    setIn(HI, 16'h0, ON, ON);
    edges(DLY - 2);
    setIn(HI, 16'h0, ON, 16'h0);
    setIn(HI, 16'h0, ON, ON);
    edges(DLY);
    chk(gateDrive, 1'b0, "timer not cleared");
    edges(1);
    chk(gateDrive, 1'b1, "restart gate late");
    // monitor low drops at the next edge
    setIn(HI, 16'h0, 16'h0, ON);
    edges(1);
    chk(gateDrive, 1'b0, "gate held after monitor low");
    // second reset in mid-run, asserted on a rising edge
    setIn(HI, 16'h0, ON, ON);
    edges(DLY + 3);
    @(posedge clk_sys);
    resetn <= 1'b0;
    #1;
    chk(gateDrive, 1'b0, "gate after mid reset");
    chk(lockoutActive, 1'b1, "lockout after mid reset");
    edges(3);
    // release with inputs already good: lockout clears first, count starts next
    @(posedge clk_sys);
    resetn <= 1'b1;
    edges(1);
    chk(lockoutActive, 1'b0, "lockout held after release");
    chk(timerRunning, 1'b0, "timer ran on first edge");
    edges(1);
    chk(timerRunning, 1'b1, "timer idle after release");
    edges(DLY - 1);
    chk(gateDrive, 1'b0, "gate early after release");
    edges(1);
    chk(gateDrive, 1'b1, "gate late after release");
    stopTest;
  end
endmodule : test_two_supply_gate_sequencer
`default_nettype wire
